// ==== hseq_axis.sv ====
// Behavioural axis: position, limit and reference switches, index track, end stops
`timescale 1ns/1ps
`default_nettype none
module hseq_axis (
	// Clock and bench control
	input  wire logic        aclk,
	input  wire logic        zero,
	input  wire logic        jam,
	// Motion commands
	input  wire logic        move_req,
	input  wire logic        move_dir,
	input  wire logic [1:0]  move_spd,
	input  wire logic        move_to_pos,
	input  wire logic [31:0] pos_target,
	// Sensing
	output logic             lim_pos,
	output logic             lim_neg,
	output logic             ref_sw,
	output logic             index_pulse,
	output logic [15:0]      i2t_val,
	output logic [31:0]      act_pos,
	output logic             pos_reached
);
	logic signed [31:0] p_q;
	logic signed [31:0] nx;
	logic               push_q;
	assign act_pos     = p_q;
	assign lim_pos     = p_q >= 400;
	assign lim_neg     = p_q <= -400;
	assign ref_sw      = p_q >= 200 && p_q < 240;
	// A jammed axis never sees an index mark
	assign index_pulse = p_q[5:0] == 6'h00 && !jam;
	assign i2t_val     = push_q ? 16'h00C8 : 16'h0064;
	assign pos_reached = move_to_pos && p_q == pos_target;
	assign nx = move_dir ? p_q + ((move_spd == hseq_pkg::SPD_CRAWL) ? 1 : 4)
		: p_q - ((move_spd == hseq_pkg::SPD_CRAWL) ? 1 : 4);
	always_ff @(posedge aclk) begin
		push_q <= 1'b0;
		if (zero)
			p_q <= '0;
		else if (move_to_pos && !jam)
			p_q <= pos_target;
		else if (move_req && !jam) begin
			// Hard stops at +-500: current climbs while pushing
			if (nx > 500 || nx < -500) push_q <= 1'b1;
			p_q <= (nx > 500) ? 500 : (nx < -500) ? -500 : nx;
		end
	end
endmodule : hseq_axis
`default_nettype wire

// ==== hseq_pkg.sv ====
// Constants, method decoding and types for the homing sequencer
`default_nettype none
package hseq_pkg;
	// Register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_METH = 8'h04;
	localparam logic [7:0] A_STAT = 8'h08;
	localparam logic [7:0] A_OFS  = 8'h0C;
	localparam logic [7:0] A_TMO  = 8'h10;
	localparam logic [7:0] A_HOME = 8'h14;
	localparam logic [7:0] A_TRQ  = 8'h18;
	// CTRL fields
	localparam int C_START = 0;
	localparam int C_GOZ   = 1;
	localparam int C_AUTO  = 2;
	localparam int C_TMOEN = 3;
	localparam int C_TRQ   = 4;
	localparam int C_W     = 5;
	// STATUS fields
	localparam int S_DONE = 0;
	localparam int S_ERR  = 1;
	localparam int S_BUSY = 2;
	localparam int S_TMO  = 3;
	localparam int S_ST   = 4;
	// Reset values
	localparam logic [4:0]  CTRL_RST = 5'h00;
	localparam logic [7:0]  METH_RST = 8'h22;
	localparam logic [15:0] TMO_RST  = 16'h0BB8;
	// Method codes (signed 8-bit)
	localparam logic [7:0] M_STOP_P  = 8'hEE;
	localparam logic [7:0] M_STOP_N  = 8'hEF;
	localparam logic [7:0] M_STIX_1  = 8'hFF;
	localparam logic [7:0] M_STIX_2  = 8'hFE;
	localparam logic [7:0] M_LIM_P   = 8'h12;
	localparam logic [7:0] M_LIM_N   = 8'h11;
	localparam logic [7:0] M_LIX_1   = 8'h01;
	localparam logic [7:0] M_LIX_2   = 8'h02;
	localparam logic [7:0] M_REF_P   = 8'h17;
	localparam logic [7:0] M_REF_N   = 8'h1B;
	localparam logic [7:0] M_RIX_7   = 8'h07;
	localparam logic [7:0] M_RIX_11  = 8'h0B;
	localparam logic [7:0] M_REND_P  = 8'hE9;
	localparam logic [7:0] M_REND_N  = 8'hE5;
	localparam logic [7:0] M_IDX_N   = 8'h20;
	localparam logic [7:0] M_IDX_P   = 8'h21;
	localparam logic [7:0] M_HERE    = 8'h22;
	// Speed selection
	localparam logic [1:0] SPD_SEARCH = 2'h0;
	localparam logic [1:0] SPD_CRAWL  = 2'h1;
	localparam logic [1:0] SPD_NORMAL = 2'h2;
	// Stop detection: i2t rise in percent
	localparam logic [7:0] I2T_BASE_PCT = 8'h64;
	localparam logic [7:0] I2T_RISE_PCT = 8'h32;
	// Timeout check interval
	localparam int CLK_HZ   = 100_000_000;
	localparam int TICK_MS  = 10;
	localparam int TICK_CYC = TICK_MS * (CLK_HZ / 1000);
	// Bus responses
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	typedef enum {K_NONE, K_STOP, K_LIMIT, K_REF, K_REFEND, K_INDEX, K_BAD} hseq_kind_t;
	typedef enum {ST_IDLE, ST_SEARCH, ST_CRAWL, ST_INDEX, ST_FIN, ST_GOHOME, ST_SET}
		hseq_state_t;

	function automatic hseq_kind_t f_kind(input logic [7:0] m);
		unique case (m)
			M_STOP_P, M_STOP_N, M_STIX_1, M_STIX_2: f_kind = K_STOP;
			M_LIM_P, M_LIM_N, M_LIX_1, M_LIX_2:     f_kind = K_LIMIT;
			M_REF_P, M_REF_N, M_RIX_7, M_RIX_11:    f_kind = K_REF;
			M_REND_P, M_REND_N:                     f_kind = K_REFEND;
			M_IDX_N, M_IDX_P:                       f_kind = K_INDEX;
			M_HERE:                                 f_kind = K_NONE;
			default:                                f_kind = K_BAD;
		endcase
	endfunction : f_kind

	// First direction of travel, 1 = positive
	function automatic logic f_dir(input logic [7:0] m);
		f_dir = (m == M_STOP_P) || (m == M_STIX_2) || (m == M_LIM_P) || (m == M_LIX_1)
			|| (m == M_REF_P) || (m == M_RIX_7) || (m == M_REND_P) || (m == M_IDX_P);
	endfunction : f_dir

	function automatic logic f_idx(input logic [7:0] m);
		f_idx = (m == M_STIX_1) || (m == M_STIX_2) || (m == M_LIX_1) || (m == M_LIX_2)
			|| (m == M_RIX_7) || (m == M_RIX_11);
	endfunction : f_idx
endpackage : hseq_pkg
`default_nettype wire

// ==== hseq_tmo.sv ====
// Homing timeout watch sampled on a fixed tick
`timescale 1ns/1ps
`default_nettype none
module hseq_tmo #(
	parameter int TICK_CYC = hseq_pkg::TICK_CYC
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	// Control
	input  wire logic        run,
	input  wire logic [15:0] limit,
	// Result
	output logic             expired
);
	logic [31:0] cyc_q;
	logic [15:0] tick_q;
	logic        tick;

	assign tick = (cyc_q == 32'(TICK_CYC - 1));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cyc_q <= '0;
		end else if (ce) begin
			if (!run || tick)
				cyc_q <= '0;
			else
				cyc_q <= cyc_q + 32'h1;
		end
	end

	// Elapsed time is only compared at tick boundaries
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_q  <= '0;
			expired <= 1'b0;
		end else if (ce) begin
			if (!run) begin
				tick_q  <= '0;
				expired <= 1'b0;
			end else if (tick) begin
				tick_q  <= tick_q + 16'h1;
				expired <= (tick_q >= limit);
			end
		end
	end
endmodule : hseq_tmo
`default_nettype wire

// ==== hseq_top.sv ====
// Homing sequencer with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
module hseq_top #(
	parameter int TICK_CYC = hseq_pkg::TICK_CYC,
	parameter int PW       = 32
) (
	// Clock, reset, enable
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          ce,
	// AXI4-Lite write
	input  wire logic [7:0]    s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]    s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	// Start sources
	input  wire logic          di_start,
	input  wire logic          fbus_start,
	input  wire logic          drive_en,
	// Axis sensing
	input  wire logic          lim_pos,
	input  wire logic          lim_neg,
	input  wire logic          ref_sw,
	input  wire logic          index_pulse,
	input  wire logic          index_known,
	input  wire logic [15:0]   i2t_val,
	input  wire logic [15:0]   torque_val,
	input  wire logic [PW-1:0] act_pos,
	input  wire logic          pos_reached,
	// Motion commands
	output logic               move_req,
	output logic               move_dir,
	output logic [1:0]         move_spd,
	output logic               move_to_pos,
	output logic [PW-1:0]      pos_target,
	output logic               set_pos_stb,
	output logic [PW-1:0]      set_pos_val,
	// Status
	output logic               homing_done,
	output logic               homing_busy,
	output logic               homing_err
);
	hseq_pkg::hseq_state_t st_q;
	hseq_pkg::hseq_kind_t  kind_q;
	logic [hseq_pkg::C_W-1:1] ctrl_q;
	logic [7:0]    meth_q;
	logic [PW-1:0] ofs_q, cap_q, home_q;
	logic [15:0]   tmo_lim_q, trq_q, i2t_base_q;
	logic          dir_q, sdir_q, idxdir_q, useidx_q, fbus_q, endph_q;
	logic          done_q, err_q, tmo_q, first_q, here_q;
	logic          di_q, en_q, trk_q, idx_q, sw_start;
	logic          bvalid_q, rvalid_q, wr, rd;
	logic [1:0]    bresp_q, rresp_q;
	logic [31:0]   rdata_q, rmux;
	logic [31:0]   ctrl_w, meth_w, ofs_w, tmo_w, trq_w;
	logic          rhit;
	logic          start, meth_ok, lim_dir, trk, stop_det, tmo_exp;
	logic [23:0]   i2t_now, i2t_lim;

	function automatic logic [31:0] f_strb(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		for (int b = 0; b < 4; b++)
			f_strb[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
	endfunction : f_strb

	// Bus slave: address and data are taken together, one response at a time
	assign wr            = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
	assign s_axi_awready = wr;
	assign s_axi_wready  = wr;
	assign rd            = s_axi_arvalid && !rvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;
	assign sw_start      = wr && (s_axi_awaddr == hseq_pkg::A_CTRL)
		&& s_axi_wstrb[0] && s_axi_wdata[hseq_pkg::C_START];

	// Byte-lane merge of each register with the incoming write word
	assign ctrl_w = f_strb(32'(ctrl_q) << 1, s_axi_wdata, s_axi_wstrb);
	assign meth_w = f_strb(32'(meth_q), s_axi_wdata, s_axi_wstrb);
	assign ofs_w  = f_strb(32'(ofs_q), s_axi_wdata, s_axi_wstrb);
	assign tmo_w  = f_strb(32'(tmo_lim_q), s_axi_wdata, s_axi_wstrb);
	assign trq_w  = f_strb(32'(trq_q), s_axi_wdata, s_axi_wstrb);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= hseq_pkg::RESP_OK;
		end else if (ce) begin
			if (wr) begin
				bvalid_q <= 1'b1;
				unique case (s_axi_awaddr)
					hseq_pkg::A_CTRL, hseq_pkg::A_METH, hseq_pkg::A_OFS,
					hseq_pkg::A_TMO, hseq_pkg::A_TRQ: bresp_q <= hseq_pkg::RESP_OK;
					default: bresp_q <= hseq_pkg::RESP_ERR;
				endcase
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q    <= hseq_pkg::CTRL_RST[hseq_pkg::C_W-1:1];
			meth_q    <= hseq_pkg::METH_RST;
			ofs_q     <= '0;
			tmo_lim_q <= hseq_pkg::TMO_RST;
			trq_q     <= '0;
		end else if (ce && wr) begin
			unique case (s_axi_awaddr)
				hseq_pkg::A_CTRL: ctrl_q <= ctrl_w[hseq_pkg::C_W-1:1];
				// Method is frozen while a run is under way
				hseq_pkg::A_METH: if (st_q == hseq_pkg::ST_IDLE)
					meth_q <= meth_w[7:0];
				hseq_pkg::A_OFS: ofs_q <= PW'(ofs_w);
				hseq_pkg::A_TMO: tmo_lim_q <= tmo_w[15:0];
				hseq_pkg::A_TRQ: trq_q <= trq_w[15:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		rhit = 1'b1;
		rmux = '0;
		unique case (s_axi_araddr)
			hseq_pkg::A_CTRL: rmux = 32'(ctrl_q) << 1;
			hseq_pkg::A_METH: rmux = 32'(meth_q);
			hseq_pkg::A_STAT: rmux = {24'h0, 4'(st_q), tmo_q, homing_busy, err_q, done_q};
			hseq_pkg::A_OFS:  rmux = 32'(ofs_q);
			hseq_pkg::A_TMO:  rmux = 32'(tmo_lim_q);
			hseq_pkg::A_HOME: rmux = 32'(home_q);
			hseq_pkg::A_TRQ:  rmux = 32'(trq_q);
			default:          rhit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rresp_q  <= hseq_pkg::RESP_OK;
			rdata_q  <= '0;
		end else if (ce) begin
			if (rd) begin
				rvalid_q <= 1'b1;
				rdata_q  <= rmux;
				rresp_q  <= rhit ? hseq_pkg::RESP_OK : hseq_pkg::RESP_ERR;
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// Edge history of start and axis inputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			di_q    <= 1'b0;
			en_q    <= 1'b0;
			trk_q   <= 1'b0;
			idx_q   <= 1'b0;
			first_q <= 1'b1;
		end else if (ce) begin
			di_q  <= di_start;
			en_q  <= drive_en;
			trk_q <= trk;
			idx_q <= index_pulse;
			if (drive_en && !en_q)
				first_q <= 1'b0;
		end
	end

	// Auto start fires only on the first enable after reset
	assign start = (st_q == hseq_pkg::ST_IDLE) && (sw_start || fbus_start
		|| (di_start && !di_q)
		|| (drive_en && !en_q && first_q && ctrl_q[hseq_pkg::C_AUTO]));
	assign meth_ok = (hseq_pkg::f_kind(meth_q) != hseq_pkg::K_BAD);
	assign lim_dir = dir_q ? lim_pos : lim_neg;
	assign trk     = (kind_q == hseq_pkg::K_LIMIT) ? (sdir_q ? lim_pos : lim_neg) : ref_sw;
	assign i2t_now = 24'(i2t_val) * 24'(hseq_pkg::I2T_BASE_PCT);
	assign i2t_lim = 24'(i2t_base_q) * 24'(hseq_pkg::I2T_BASE_PCT + hseq_pkg::I2T_RISE_PCT);
	assign stop_det = ctrl_q[hseq_pkg::C_TRQ] ? (torque_val >= trq_q)
		: (i2t_now >= i2t_lim);

	hseq_tmo #(.TICK_CYC(TICK_CYC)) u_tmo (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.run     (homing_busy && ctrl_q[hseq_pkg::C_TMOEN]),
		.limit   (tmo_lim_q),
		.expired (tmo_exp)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= hseq_pkg::ST_IDLE;
			kind_q <= hseq_pkg::K_NONE;
			{dir_q, sdir_q, idxdir_q, useidx_q, fbus_q, endph_q, here_q} <= '0;
			{done_q, err_q, tmo_q, move_req, move_to_pos, set_pos_stb} <= '0;
			move_spd <= hseq_pkg::SPD_SEARCH;
			{cap_q, home_q, pos_target, set_pos_val} <= '0;
			i2t_base_q <= '0;
		end else if (ce) begin
			set_pos_stb <= 1'b0;
			if (tmo_exp && st_q != hseq_pkg::ST_IDLE) begin
				st_q <= hseq_pkg::ST_IDLE;
				err_q <= 1'b1;
				tmo_q <= 1'b1;
				move_req <= 1'b0;
			end else unique case (st_q)
				hseq_pkg::ST_IDLE: if (start) begin
					{done_q, err_q, tmo_q} <= '0;
					if (!meth_ok) begin
						err_q <= 1'b1;
					end else begin
						kind_q <= hseq_pkg::f_kind(meth_q);
						dir_q <= hseq_pkg::f_dir(meth_q);
						sdir_q <= hseq_pkg::f_dir(meth_q);
						useidx_q <= hseq_pkg::f_idx(meth_q);
						idxdir_q <= ~hseq_pkg::f_dir(meth_q);
						fbus_q <= fbus_start;
						endph_q <= (hseq_pkg::f_kind(meth_q) == hseq_pkg::K_REFEND);
						here_q <= (meth_q == hseq_pkg::M_HERE);
						i2t_base_q <= i2t_val;
						move_to_pos <= 1'b0;
						if (meth_q == hseq_pkg::M_HERE) begin
							cap_q <= act_pos;
							st_q <= hseq_pkg::ST_FIN;
						end else begin
							move_req <= 1'b1;
							if (hseq_pkg::f_kind(meth_q) == hseq_pkg::K_INDEX) begin
								move_spd <= hseq_pkg::SPD_CRAWL;
								st_q <= hseq_pkg::ST_INDEX;
							end else begin
								move_spd <= hseq_pkg::SPD_SEARCH;
								st_q <= hseq_pkg::ST_SEARCH;
							end
						end
					end
				end
				hseq_pkg::ST_SEARCH: unique case (kind_q)
					hseq_pkg::K_STOP: if (stop_det) begin
						cap_q <= act_pos;
						dir_q <= idxdir_q;
						move_spd <= hseq_pkg::SPD_CRAWL;
						if (useidx_q && !index_known) begin
							st_q <= hseq_pkg::ST_INDEX;
						end else begin
							move_req <= 1'b0;
							st_q <= hseq_pkg::ST_FIN;
						end
					end
					hseq_pkg::K_LIMIT: if (lim_dir) begin
						dir_q <= ~dir_q;
						move_spd <= hseq_pkg::SPD_CRAWL;
						st_q <= hseq_pkg::ST_CRAWL;
					end
					default: if (endph_q) begin
						if (lim_dir) begin
							endph_q <= 1'b0;
							dir_q <= ~dir_q;
						end
					end else if (ref_sw) begin
						dir_q <= ~dir_q;
						move_spd <= hseq_pkg::SPD_CRAWL;
						st_q <= hseq_pkg::ST_CRAWL;
					end else if (lim_dir) begin
						dir_q <= ~dir_q;
					end
				endcase
				hseq_pkg::ST_CRAWL: if (trk_q && !trk) begin
					cap_q <= act_pos;
					dir_q <= idxdir_q;
					if (useidx_q && !index_known) begin
						st_q <= hseq_pkg::ST_INDEX;
					end else begin
						move_req <= 1'b0;
						st_q <= hseq_pkg::ST_FIN;
					end
				end
				hseq_pkg::ST_INDEX: if (index_pulse && !idx_q) begin
					cap_q <= act_pos;
					move_req <= 1'b0;
					st_q <= hseq_pkg::ST_FIN;
				end
				hseq_pkg::ST_FIN: begin
					home_q <= here_q ? cap_q : cap_q + ofs_q;
					pos_target <= here_q ? cap_q : cap_q + ofs_q;
					if (ctrl_q[hseq_pkg::C_GOZ] && !fbus_q && !here_q) begin
						move_req <= 1'b1;
						move_to_pos <= 1'b1;
						move_spd <= hseq_pkg::SPD_NORMAL;
						st_q <= hseq_pkg::ST_GOHOME;
					end else begin
						st_q <= hseq_pkg::ST_SET;
					end
				end
				hseq_pkg::ST_GOHOME: if (pos_reached) begin
					move_req <= 1'b0;
					move_to_pos <= 1'b0;
					st_q <= hseq_pkg::ST_SET;
				end
				hseq_pkg::ST_SET: begin
					set_pos_stb <= 1'b1;
					set_pos_val <= act_pos - home_q;
					done_q <= 1'b1;
					st_q <= hseq_pkg::ST_IDLE;
				end
			endcase
		end
	end

	assign move_dir    = dir_q;
	assign homing_done = done_q;
	assign homing_busy = (st_q != hseq_pkg::ST_IDLE);
	assign homing_err  = err_q;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !ce);

	sequence s_go;
		start && meth_ok;
	endsequence
	sequence s_srch;
		st_q == hseq_pkg::ST_SEARCH;
	endsequence

	property p_start_bad;
		start && !meth_ok |=> err_q && !homing_busy && !move_req;
	endproperty
	a_start_bad: assert property (p_start_bad) else $error("bad method not refused");

	property p_di_start;
		di_start && !di_q && st_q == hseq_pkg::ST_IDLE && meth_ok |=> homing_busy;
	endproperty
	a_di_start: assert property (p_di_start) else $error("input start ignored");

	property p_search_spd;
		s_go ##1 s_srch |-> move_req && move_spd == hseq_pkg::SPD_SEARCH;
	endproperty
	a_search_spd: assert property (p_search_spd) else $error("search not at search speed");

	property p_here;
		s_go and (meth_q == hseq_pkg::M_HERE)
			|=> !move_req ##2 set_pos_stb && set_pos_val == '0;
	endproperty
	a_here: assert property (p_here) else $error("code 34 did not zero position");

	property p_stop;
		s_srch and (kind_q == hseq_pkg::K_STOP && stop_det) |=> st_q != hseq_pkg::ST_SEARCH;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not taken");

	property p_rev;
		s_srch and (kind_q == hseq_pkg::K_REF && !ref_sw && lim_dir)
			|=> dir_q != $past(dir_q);
	endproperty
	a_rev: assert property (p_rev) else $error("no reversal at limit");

	property p_fbus;
		st_q == hseq_pkg::ST_FIN && fbus_q |=> st_q == hseq_pkg::ST_SET ##1 done_q;
	endproperty
	a_fbus: assert property (p_fbus) else $error("fieldbus run moved home");

	property p_goz;
		st_q == hseq_pkg::ST_FIN && ctrl_q[hseq_pkg::C_GOZ] && !fbus_q && !here_q
			|=> move_to_pos && move_req && pos_target == home_q;
	endproperty
	a_goz: assert property (p_goz) else $error("no move to home");

	property p_tmo;
		tmo_exp && homing_busy |=> err_q && !homing_busy && !move_req;
	endproperty
	a_tmo: assert property (p_tmo) else $error("timeout not raised");
endmodule : hseq_top
`default_nettype wire

// ==== test_hseq_top.sv ====
// Self-checking bench for the homing sequencer
`timescale 1ns/1ps
`default_nettype none
module test_hseq_top;
	logic        aclk, aresetn, ce, zero, jam, saw_mtp, saw_crawl;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, act_pos, pos_target, set_pos_val, v;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, move_spd;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        di_start, fbus_start, drive_en, lim_pos, lim_neg, ref_sw, index_pulse;
	logic        index_known, pos_reached, move_req, move_dir, move_to_pos, set_pos_stb;
	logic        homing_done, homing_busy, homing_err;
	logic [15:0] i2t_val, torque_val;
	logic [33:0] rq[$], bq[$], pq[$];
	logic [7:0]  codes[16] = '{8'hEE, 8'hEF, 8'hFF, 8'hFE, 8'h12, 8'h11, 8'h01, 8'h02,
		8'h17, 8'h1B, 8'h07, 8'h0B, 8'hE9, 8'hE5, 8'h20, 8'h21};
	int          bad_count, samples_checked, cyc, seed, k;

	hseq_top #(.TICK_CYC(10)) uut (.*);
	hseq_axis axis (.*);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic stop_test();
		$display("checks=%0d errors=%0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [33:0] g, input logic [33:0] e, input bit tol);
		logic signed [33:0] d;
		logic               ok;
		d = g - e;
		// Final position may trail the captured edge by a few crawl steps
		ok = tol ? (d >= -4 && d <= 4) : (g === e);
		samples_checked++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = hseq_pkg::RESP_OK);
		bq.push_back({r, 32'h0});
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_awready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = hseq_pkg::RESP_OK);
		rq.push_back({r, d});
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic wait_end();
		for (k = 0; k < 5000 && !(homing_done || homing_err); k++) @(posedge aclk);
		#1;
	endtask : wait_end

	task automatic run_one(input logic [7:0] m, input logic [15:0] d, input int src,
		input logic [15:0] cr);
		wr(hseq_pkg::A_METH, {24'h0, m});
		@(posedge aclk) zero <= 1'b1;
		@(posedge aclk) zero <= 1'b0;
		index_known <= (m == hseq_pkg::M_RIX_11);
		saw_mtp = 1'b0;
		saw_crawl = 1'b0;
		pq.push_back(34'h0);
		// Torque compare mode from the M_STOP_P run through the M_STIX_1 run, i2t rise for the rest
		if (src == 0) wr(hseq_pkg::A_CTRL, (m == hseq_pkg::M_STOP_P) ? 32'h13 : 32'h3);
		else begin
			@(posedge aclk);
			if (src == 1) fbus_start <= 1'b1;
			else di_start <= 1'b1;
			@(posedge aclk);
			fbus_start <= 1'b0;
			di_start <= 1'b0;
		end
		for (k = 0; k < 20 && homing_busy !== 1'b1; k++) @(posedge aclk);
		@(posedge aclk);
		#1 chk({move_req, move_dir}, {1'b1, d[0]}, 0);
		if (m[7:1] != 7'h10) chk(move_spd, hseq_pkg::SPD_SEARCH, 0);
		wait_end();
		chk({homing_err, homing_done}, 2'b01, 0);
		chk(saw_mtp, src != 1, 0);
		if (cr[0]) chk(saw_crawl, 1'b1, 0);
		// Torque trips one step past 480, well short of the hard stop at 500
		if (m == hseq_pkg::M_STOP_P) rd(hseq_pkg::A_HOME, 32'h000001E4);
	endtask : run_one

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		torque_val <= ($signed(act_pos) >= 480 || $signed(act_pos) <= -480) ? 16'hFFFF : 16'h0000;
		if (move_to_pos === 1'b1) saw_mtp <= 1'b1;
		if (move_req === 1'b1 && move_spd === hseq_pkg::SPD_CRAWL) saw_crawl <= 1'b1;
		if (set_pos_stb === 1'b1)
			chk({{2{set_pos_val[31]}}, set_pos_val}, pq.size() ? pq.pop_front() : 34'h1FF, 1);
		if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front(), 0);
		if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, bq.pop_front(), 0);
		if (cyc == 60000) begin
			bad_count++;
			stop_test();
		end
	end

	initial begin
		{aresetn, jam, di_start, fbus_start, drive_en, index_known} = '0;
		// Axis position has no reset of its own: hold it at zero meanwhile
		zero = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		ce = 1'b1;
		seed = 32'h21FF;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		zero <= 1'b0;
		rd(hseq_pkg::A_CTRL, 32'h0);
		rd(hseq_pkg::A_METH, 32'h22);
		rd(hseq_pkg::A_TMO, 32'hBB8);
		rd(hseq_pkg::A_OFS, 32'h0);
		rd(8'h1C, 32'h0, hseq_pkg::RESP_ERR);
		wr(hseq_pkg::A_STAT, 32'h7, hseq_pkg::RESP_ERR);
		v = $random(seed);
		// A zero compare value would trip the torque stop at once
		v[0] = 1'b1;
		wr(hseq_pkg::A_TRQ, {16'h0, v[15:0]});
		rd(hseq_pkg::A_TRQ, {16'h0, v[15:0]});
		// Code 34 is the reset method; first enable with auto start
		wr(hseq_pkg::A_CTRL, 32'h4);
		pq.push_back(34'h0);
		@(posedge aclk) drive_en <= 1'b1;
		repeat (2) @(posedge aclk);
		wait_end();
		chk({homing_err, homing_done, move_req}, 3'b010, 0);
		wr(hseq_pkg::A_METH, 32'h5);
		wr(hseq_pkg::A_CTRL, 32'h1);
		repeat (3) @(posedge aclk);
		#1 chk({homing_err, homing_done}, 2'b10, 0);
		for (int i = 0; i < 16; i++)
			run_one(codes[i], 16'h9559 >> i, i % 3, 16'h3FF0 >> i);
		// Jammed axis never finds the index: watch must expire
		jam <= 1'b1;
		wr(hseq_pkg::A_TMO, 32'h3);
		wr(hseq_pkg::A_METH, 32'h21);
		wr(hseq_pkg::A_CTRL, 32'h9);
		repeat (12) @(posedge aclk);
		#1 chk(homing_err, 1'b0, 0);
		repeat (45) @(posedge aclk);
		#1 chk({homing_err, homing_done}, 2'b10, 0);
		stop_test();
	end
endmodule : test_hseq_top
`default_nettype wire
